// *** pcc_chan.v ***
`include "pcc_consts.vh"

module pcc_chan (
    input  wire        sys_clk,    // system clock
    input  wire        rstn,       // async reset, active low
    input  wire        pwm_en,     // channel in pwm mode
    input  wire        pwm16,      // channel in 16-bit pwm
    input  wire [10:0] len_mask,   // mask of the short cycle length
    input  wire [15:0] cnt,        // main array counter value
    input  wire        tick,       // counter advances this cycle
    input  wire        ovf_hit,    // short cycle overflow this cycle
    input  wire [15:0] cc_val,     // capture/compare register
    input  wire [15:0] ar_val,     // auto-reload register
    input  wire        clr_evt,    // comparator clear edge seen
    input  wire        clr_en,     // comparator clear enabled here
    output wire        chan_out    // pwm output of the channel
);

    reg  [15:0] active_q;
    reg  [15:0] active_d;
    reg         cleared_q;
    reg         out_q;
    wire        start;
    wire [15:0] cnt_m;
    wire        match;

    // 16-bit channels ignore the length field and wrap at full count
    assign start = pwm16 ? (tick & (&cnt)) : ovf_hit;
    assign cnt_m = pwm16 ? cnt : {5'h00, cnt[10:0] & len_mask};
    assign match = (cnt_m == active_q);

    // reload source: reload bank only for 9 to 11 bit cycles
    always @* begin
        if (pwm16) begin
            active_d = cc_val;
        end else if (len_mask == `PCC_MASK_8) begin
            active_d = {8'h00, cc_val[15:8]};
        end else begin
            active_d = {5'h00, ar_val[10:0] & len_mask};
        end
    end

    // compare value is latched at cycle start so mid-cycle writes do not glitch
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            active_q <= `PCC_RST_WORD;
        end else if (start) begin
            active_q <= active_d;
        end
    end

    // output low at cycle start, high at match, held low after a clear
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            out_q     <= 1'b0;
            cleared_q <= 1'b0;
        end else if (!pwm_en) begin
            out_q     <= 1'b0;
            cleared_q <= 1'b0;
        end else if (clr_evt && clr_en) begin
            out_q     <= 1'b0;
            cleared_q <= 1'b1;
        end else if (start) begin
            out_q     <= 1'b0;
            cleared_q <= 1'b0;
        end else if (match && !cleared_q) begin
            out_q     <= 1'b1;
        end
    end

    assign chan_out = out_q;

endmodule

// *** pcc_chk.sv ***
`include "pcc_consts.vh"

module pcc_chk (
    input logic        sys_clk,            // clock
    input logic        rstn,               // reset, active low
    input logic [7:0]  reg_addr,           // address
    input logic [7:0]  reg_wdata,          // write data
    input logic        reg_wr,             // write strobe
    input logic        reg_rd,             // read strobe
    input logic [7:0]  reg_rdata,          // read data
    input logic [15:0] main_array_counter, // counter
    input logic        cnt_tick,           // counter step
    input logic [2:0]  pwm_mode_en,        // pwm mode
    input logic [2:0]  pwm16_en,           // 16-bit pwm
    input logic        cmp_result,         // comparator level
    input logic [2:0]  channel_out,        // outputs
    input logic [47:0] cc_value,           // compare registers
    input logic        cycle_ovf_irq       // interrupt request
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [7:0]  cfg_q;
    logic [7:0]  clr_q;
    logic [10:0] mask;
    logic        wrap;

    // shadows of the config registers, rebuilt from bus writes
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= 8'h00;
            clr_q <= 8'h00;
        end else if (reg_wr && reg_addr == `PCC_ADDR_PWM_CFG) begin
            cfg_q <= reg_wdata;
        end else if (reg_wr && reg_addr == `PCC_ADDR_CLR_CTRL) begin
            clr_q <= reg_wdata;
        end
    end

    // wrap step of the selected cycle length
    assign mask = 11'h7FF >> (2'h3 - cfg_q[1:0]);
    assign wrap = cnt_tick && ((main_array_counter[10:0] & mask) == mask);

    chk_flag_wrap: assert property (wrap && cfg_q[6] && !reg_wr |=> cycle_ovf_irq)
        else $error("overflow flag missed the wrap step");
    chk_flag_nowrap: assert property (cnt_tick && !wrap && cfg_q[6] && !cycle_ovf_irq
        && !reg_wr |=> !cycle_ovf_irq)
        else $error("overflow flag set off the wrap step");
    chk_flag_hold: assert property (cycle_ovf_irq && !reg_wr |=> cycle_ovf_irq)
        else $error("overflow flag dropped without a write");
    chk_sw_set: assert property (reg_wr && reg_addr == `PCC_ADDR_PWM_CFG
        && reg_wdata[6] && reg_wdata[5] |=> cycle_ovf_irq)
        else $error("software set of flag lost");
    chk_irq_mask: assert property (reg_wr && reg_addr == `PCC_ADDR_PWM_CFG
        && !reg_wdata[6] |=> !cycle_ovf_irq)
        else $error("interrupt while masked");
    chk_unused_zero: assert property (reg_rd && reg_addr == `PCC_ADDR_PWM_CFG
        |=> reg_rdata[4:2] == 3'b000)
        else $error("unused config bits read nonzero");
    chk_clear_fall: assert property ($past(rstn, 2) && $fell(cmp_result) && !clr_q[7]
        && clr_q[0] && !reg_wr |-> ##[1:3] !channel_out[0])
        else $error("falling clear missed channel 0");
    chk_clear_rise: assert property ($past(rstn, 2) && $rose(cmp_result) && clr_q[7]
        && clr_q[1] && !reg_wr |-> ##[1:3] !channel_out[1])
        else $error("rising clear missed channel 1");
    chk_reset_zero: assert property ($rose(rstn) |-> reg_rdata == 8'h00
        && channel_out == 3'b000 && !cycle_ovf_irq)
        else $error("outputs not zero after reset");
endmodule

bind pcc_top pcc_chk pcc_chk_i (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .main_array_counter(main_array_counter), .cnt_tick(cnt_tick),
    .pwm_mode_en(pwm_mode_en), .pwm16_en(pwm16_en), .cmp_result(cmp_result),
    .channel_out(channel_out), .cc_value(cc_value), .cycle_ovf_irq(cycle_ovf_irq));

// *** pcc_consts.vh ***
`ifndef PCC_CONSTS_VH
`define PCC_CONSTS_VH

// register addresses on the 8-bit register port
`define PCC_ADDR_CLR_CTRL    8'hCE
`define PCC_ADDR_PWM_CFG     8'hF7
`define PCC_ADDR_CMP_BASE    8'hE0
`define PCC_ADDR_CMP_LAST    8'hE5

// pwm_cycle_config fields
`define PCC_CFG_BANK_BIT     7
`define PCC_CFG_IRQEN_BIT    6
`define PCC_CFG_FLAG_BIT     5
`define PCC_CFG_LEN_HI       1
`define PCC_CFG_LEN_LO       0

// comparator_clear_control fields
`define PCC_CLR_POL_BIT      7
`define PCC_CLR_RSV_HI       6
`define PCC_CLR_RSV_LO       3
`define PCC_CLR_EN_HI        2
`define PCC_CLR_EN_LO        0

// reset values
`define PCC_RST_BYTE         8'h00
`define PCC_RST_WORD         16'h0000
`define PCC_RST_LEN          2'h0

// cycle length encodings
`define PCC_LEN_8            2'h0
`define PCC_LEN_9            2'h1
`define PCC_LEN_10           2'h2
`define PCC_LEN_11           2'h3

// counter masks for the short cycle lengths
`define PCC_MASK_8           11'h0FF
`define PCC_MASK_9           11'h1FF
`define PCC_MASK_10          11'h3FF
`define PCC_MASK_11          11'h7FF

// channel count
`define PCC_NCH              3

`endif

// *** pcc_top.v ***
`include "pcc_consts.vh"

module pcc_top (
    input  wire        sys_clk,            // system clock, 100 MHz
    input  wire        rstn,               // async reset, active low
    input  wire [7:0]  reg_addr,           // register address
    input  wire [7:0]  reg_wdata,          // register write data
    input  wire        reg_wr,             // write strobe, one cycle
    input  wire        reg_rd,             // read strobe, one cycle
    output wire [7:0]  reg_rdata,          // read data, cycle after strobe
    input  wire [15:0] main_array_counter, // main counter value
    input  wire        cnt_tick,           // counter increments this cycle
    input  wire [2:0]  pwm_mode_en,        // per channel pwm mode
    input  wire [2:0]  pwm16_en,           // per channel 16-bit pwm
    input  wire        cmp_result,         // comparator output level
    output wire [2:0]  channel_out,        // pwm outputs, channel 0 in bit 0
    output wire [47:0] cc_value,           // compare registers, channel 0 low
    output wire        cycle_ovf_irq       // interrupt request, level
);

    // pwm_cycle_config storage
    reg         reload_bank_select_q;
    reg         cycle_ovf_irq_enable_q;
    reg         cycle_ovf_flag_q;
    reg         cycle_ovf_flag_d;
    reg  [1:0]  cycle_length_sel_q;

    // comparator_clear_control storage
    reg         cmp_clear_polarity_q;
    reg  [3:0]  clr_rsv_q;
    reg  [2:0]  cmp_clear_en_q;

    // read path and comparator edge tracking
    reg  [7:0]  rdata_q;
    reg  [7:0]  rdata_d;
    reg         cmp_prev_q;
    reg         cmp_seen_q;

    // decode and derived signals
    reg  [10:0] len_mask;
    wire        wr_cfg;
    wire        wr_clr;
    wire        cmp_hit;
    wire [7:0]  cmp_off;
    wire [1:0]  cmp_idx;
    wire        cmp_hi;
    wire        ovf_hit;
    wire        cmp_rise;
    wire        cmp_fall;
    wire        clr_evt;
    wire [47:0] cc_flat;
    wire [47:0] ar_flat;
    wire [15:0] rd_cc;
    wire [15:0] rd_ar;
    wire [7:0]  cfg_rd;
    wire [7:0]  clr_rd;

    // address decode for the two configuration registers
    assign wr_cfg  = reg_wr && (reg_addr == `PCC_ADDR_PWM_CFG);
    assign wr_clr  = reg_wr && (reg_addr == `PCC_ADDR_CLR_CTRL);

    // compare window holds low/high pairs, one pair per channel
    assign cmp_hit = (reg_addr >= `PCC_ADDR_CMP_BASE) && (reg_addr <= `PCC_ADDR_CMP_LAST);
    assign cmp_off = reg_addr - `PCC_ADDR_CMP_BASE;
    assign cmp_idx = cmp_off[2:1];
    assign cmp_hi  = cmp_off[0];

    // length field to counter mask
    always @* begin
        case (cycle_length_sel_q)
            `PCC_LEN_8: begin
                len_mask = `PCC_MASK_8;
            end
            `PCC_LEN_9: begin
                len_mask = `PCC_MASK_9;
            end
            `PCC_LEN_10: begin
                len_mask = `PCC_MASK_10;
            end
            default: begin
                len_mask = `PCC_MASK_11;
            end
        endcase
    end

    // wrap out of the selected bit: all bits under the mask are ones as the counter steps
    assign ovf_hit = cnt_tick && (&(main_array_counter[10:0] | ~len_mask));

    // flag: hardware set wins over a software clear in the same cycle
    always @* begin
        cycle_ovf_flag_d = cycle_ovf_flag_q;
        if (wr_cfg) begin
            cycle_ovf_flag_d = reg_wdata[`PCC_CFG_FLAG_BIT];
        end
        if (ovf_hit) begin
            cycle_ovf_flag_d = 1'b1;
        end
    end

    // pwm_cycle_config register; bits 4:2 have no storage
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reload_bank_select_q   <= 1'b0;
            cycle_ovf_irq_enable_q <= 1'b0;
            cycle_ovf_flag_q       <= 1'b0;
            cycle_length_sel_q     <= `PCC_RST_LEN;
        end else begin
            cycle_ovf_flag_q <= cycle_ovf_flag_d;
            if (wr_cfg) begin
                reload_bank_select_q   <= reg_wdata[`PCC_CFG_BANK_BIT];
                cycle_ovf_irq_enable_q <= reg_wdata[`PCC_CFG_IRQEN_BIT];
                cycle_length_sel_q     <= reg_wdata[`PCC_CFG_LEN_HI:`PCC_CFG_LEN_LO];
            end
        end
    end

    // comparator_clear_control register; reserved bits kept as written
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_clear_polarity_q <= 1'b0;
            clr_rsv_q            <= 4'h0;
            cmp_clear_en_q       <= 3'h0;
        end else if (wr_clr) begin
            cmp_clear_polarity_q <= reg_wdata[`PCC_CLR_POL_BIT];
            clr_rsv_q            <= reg_wdata[`PCC_CLR_RSV_HI:`PCC_CLR_RSV_LO];
            cmp_clear_en_q       <= reg_wdata[`PCC_CLR_EN_HI:`PCC_CLR_EN_LO];
        end
    end

    // interrupt request is a plain level, the counter array's vector logic lies outside
    assign cycle_ovf_irq = cycle_ovf_flag_q & cycle_ovf_irq_enable_q;

    // comparator edge detect; the first sample after reset only primes the history
    // so a comparator that is already high cannot fake a rising edge
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cmp_prev_q <= 1'b0;
            cmp_seen_q <= 1'b0;
        end else begin
            cmp_prev_q <= cmp_result;
            cmp_seen_q <= 1'b1;
        end
    end

    assign cmp_rise = cmp_seen_q && !cmp_prev_q && cmp_result;
    assign cmp_fall = cmp_seen_q && cmp_prev_q && !cmp_result;
    assign clr_evt  = cmp_clear_polarity_q ? cmp_rise : cmp_fall;

    // per channel: compare and reload banks sharing one address pair, plus the pwm logic
    genvar g;
    generate
        for (g = 0; g < `PCC_NCH; g = g + 1) begin : g_ch
            reg  [15:0] cc_q;
            reg  [15:0] ar_q;
            wire        sel;
            wire        wr_lo;
            wire        wr_hi;

            assign sel   = reg_wr && cmp_hit && (cmp_idx == g);
            assign wr_lo = sel && !cmp_hi;
            assign wr_hi = sel && cmp_hi;

            // bank select steers the write to one bank, the other keeps its value
            always @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    cc_q <= `PCC_RST_WORD;
                    ar_q <= `PCC_RST_WORD;
                end else if (reload_bank_select_q) begin
                    if (wr_lo) begin
                        ar_q[7:0] <= reg_wdata;
                    end
                    if (wr_hi) begin
                        ar_q[15:8] <= reg_wdata;
                    end
                end else begin
                    if (wr_lo) begin
                        cc_q[7:0] <= reg_wdata;
                    end
                    if (wr_hi) begin
                        cc_q[15:8] <= reg_wdata;
                    end
                end
            end

            assign cc_flat[g*16 +: 16] = cc_q;
            assign ar_flat[g*16 +: 16] = ar_q;

            pcc_chan u_chan (
                .sys_clk  (sys_clk),
                .rstn     (rstn),
                .pwm_en   (pwm_mode_en[g]),
                .pwm16    (pwm16_en[g]),
                .len_mask (len_mask),
                .cnt      (main_array_counter),
                .tick     (cnt_tick),
                .ovf_hit  (ovf_hit),
                .cc_val   (cc_q),
                .ar_val   (ar_q),
                .clr_evt  (clr_evt),
                .clr_en   (cmp_clear_en_q[g]),
                .chan_out (channel_out[g])
            );
        end
    endgenerate

    assign cc_value = cc_flat;

    // readback images of the configuration registers
    assign cfg_rd = {reload_bank_select_q, cycle_ovf_irq_enable_q, cycle_ovf_flag_q,
                     3'h0, cycle_length_sel_q};
    assign clr_rd = {cmp_clear_polarity_q, clr_rsv_q, cmp_clear_en_q};

    // index 3 lies outside the window and is never selected by cmp_hit
    assign rd_cc = (cmp_idx == 2'h3) ? `PCC_RST_WORD : cc_flat[cmp_idx*16 +: 16];
    assign rd_ar = (cmp_idx == 2'h3) ? `PCC_RST_WORD : ar_flat[cmp_idx*16 +: 16];

    // read mux; unmapped addresses read zero
    always @* begin
        rdata_d = `PCC_RST_BYTE;
        if (reg_addr == `PCC_ADDR_PWM_CFG) begin
            rdata_d = cfg_rd;
        end else if (reg_addr == `PCC_ADDR_CLR_CTRL) begin
            rdata_d = clr_rd;
        end else if (cmp_hit && reload_bank_select_q) begin
            rdata_d = cmp_hi ? rd_ar[15:8] : rd_ar[7:0];
        end else if (cmp_hit) begin
            rdata_d = cmp_hi ? rd_cc[15:8] : rd_cc[7:0];
        end
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= `PCC_RST_BYTE;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= `PCC_RST_BYTE;
        end
    end

    assign reg_rdata = rdata_q;

endmodule

// *** testbench.sv ***
`include "pcc_consts.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk, rstn, reg_wr, reg_rd, cnt_tick, cmp_result, run;
    logic [7:0]  reg_addr, reg_wdata;
    logic [15:0] main_array_counter;
    logic [2:0]  pwm_mode_en, pwm16_en;
    wire  [7:0]  reg_rdata;
    wire  [2:0]  channel_out;
    wire  [47:0] cc_value;
    wire         cycle_ovf_irq;
    int          n_mismatch;
    int          cmp_count;

    pcc_top pcc_top_i (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .main_array_counter(main_array_counter), .cnt_tick(cnt_tick),
        .pwm_mode_en(pwm_mode_en), .pwm16_en(pwm16_en), .cmp_result(cmp_result),
        .channel_out(channel_out), .cc_value(cc_value), .cycle_ovf_irq(cycle_ovf_irq));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // free-running counter, only while tasks leave it alone
    always @(posedge sys_clk) begin
        if (run) main_array_counter <= main_array_counter + 16'h0001;
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run;
        $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // one-cycle bus strobes; read data sampled in the following cycle only
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    // single counter step with the value shown before the increment
    task automatic step(input logic [15:0] v);
        @(posedge sys_clk);
        main_array_counter <= v;
        cnt_tick <= 1'b1;
        @(posedge sys_clk);
        cnt_tick <= 1'b0;
        #1;
    endtask

    task automatic wait_cnt(input logic [7:0] v);
        repeat (600) begin
            @(posedge sys_clk);
            if (main_array_counter[7:0] == v) break;
        end
        // a counter that never reaches the value is a failed run, not a silent skip
        if (main_array_counter[7:0] !== v) n_mismatch++;
    endtask

    // edge needs a few cycles to reach the outputs
    task automatic cmp_to(input logic v);
        @(posedge sys_clk);
        cmp_result <= v;
        repeat (4) @(posedge sys_clk);
        #1;
    endtask

    initial begin
        #500000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        logic [15:0] m;
        {rstn, reg_wr, reg_rd, cnt_tick, run, reg_addr, reg_wdata} = '0;
        {main_array_counter, pwm_mode_en, pwm16_en} = '0;
        cmp_result = 1'b1;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(`PCC_ADDR_PWM_CFG, 8'h00);
        rd(`PCC_ADDR_CLR_CTRL, 8'h00);
        check(cc_value, 48'h0);
        rd(8'h10, 8'h00);
        wr(`PCC_ADDR_PWM_CFG, 8'h1F);
        rd(`PCC_ADDR_PWM_CFG, 8'h03);
        wr(`PCC_ADDR_CLR_CTRL, 8'h7A);
        rd(`PCC_ADDR_CLR_CTRL, 8'h7A);
        // compare bank, then reload bank behind the same addresses
        wr(`PCC_ADDR_PWM_CFG, 8'h00);
        for (int i = 0; i < 6; i++) wr(8'(`PCC_ADDR_CMP_BASE + i), 8'(8'hA0 + i));
        check(cc_value, 48'hA5A4A3A2A1A0);
        wr(`PCC_ADDR_PWM_CFG, 8'h80);
        wr(`PCC_ADDR_CMP_BASE, 8'h11);
        wr(`PCC_ADDR_CMP_BASE + 8'h01, 8'hF0);
        check(cc_value, 48'hA5A4A3A2A1A0);
        rd(`PCC_ADDR_CMP_BASE, 8'h11);
        wr(`PCC_ADDR_PWM_CFG, 8'h00);
        rd(`PCC_ADDR_CMP_BASE, 8'hA0);
        // overflow flag for every cycle length
        for (int l = 0; l < 4; l++) begin
            m = 16'h07FF >> (3 - l);
            wr(`PCC_ADDR_PWM_CFG, 8'(8'h40 | l));
            step(m >> 1);
            check(cycle_ovf_irq, 1'b0);
            step(m);
            check(cycle_ovf_irq, 1'b1);
            rd(`PCC_ADDR_PWM_CFG, 8'(8'h60 | l));
            step(16'h0000);
            check(cycle_ovf_irq, 1'b1);
            wr(`PCC_ADDR_PWM_CFG, 8'(8'h20 | l));
            check(cycle_ovf_irq, 1'b0);
            rd(`PCC_ADDR_PWM_CFG, 8'(8'h20 | l));
            wr(`PCC_ADDR_PWM_CFG, 8'h00);
            rd(`PCC_ADDR_PWM_CFG, 8'h00);
        end
        wr(`PCC_ADDR_PWM_CFG, 8'h60);
        check(cycle_ovf_irq, 1'b1);
        wr(`PCC_ADDR_PWM_CFG, 8'h00);
        // 8-bit pwm on all channels, then comparator clears
        @(posedge sys_clk);
        pwm_mode_en <= 3'b111;
        cnt_tick <= 1'b1;
        run <= 1'b1;
        wait_cnt(8'h50);
        wait_cnt(8'hC0);
        #1;
        check(channel_out, 3'b111);
        wr(`PCC_ADDR_CLR_CTRL, 8'h05);
        cmp_to(1'b0);
        check(channel_out, 3'b010);
        wait_cnt(8'h50);
        wait_cnt(8'hC0);
        #1;
        check(channel_out, 3'b111);
        cmp_to(1'b1);
        check(channel_out, 3'b111);
        wr(`PCC_ADDR_CLR_CTRL, 8'h82);
        cmp_to(1'b0);
        check(channel_out, 3'b111);
        cmp_to(1'b1);
        check(channel_out, 3'b101);
        // freeze the counter, then step 9-bit cycles fed by the reload bank, channel 2 in 16-bit
        @(posedge sys_clk);
        run <= 1'b0;
        cnt_tick <= 1'b0;
        pwm16_en <= 3'b100;
        wr(`PCC_ADDR_CLR_CTRL, 8'h00);
        wr(`PCC_ADDR_PWM_CFG, 8'h81);
        wr(`PCC_ADDR_CMP_BASE, 8'h80);
        wr(`PCC_ADDR_CMP_BASE + 8'h01, 8'h01);
        wr(`PCC_ADDR_PWM_CFG, 8'h01);
        check(cc_value, 48'hA5A4A3A2A1A0);
        step(16'h01FF);
        check(channel_out, 3'b100);
        rd(`PCC_ADDR_PWM_CFG, 8'h21);
        step(16'h0000);
        check(channel_out, 3'b110);
        step(16'h00FF);
        check(channel_out, 3'b110);
        step(16'h00A1);
        check(channel_out, 3'b110);
        step(16'h0180);
        check(channel_out, 3'b111);
        step(16'hFFFF);
        check(channel_out, 3'b000);
        step(16'hA5A4);
        check(channel_out, 3'b100);
        complete_run();
    end
endmodule
